// [hdl/mps_regs.svh]
// Constants for the mode, privilege and exception state block.
// Assumes inclusion by the package and the design module only.
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH
`define MPS_ADDR_CTRL 4'h0
`define MPS_ADDR_STATUS 4'h4
`define MPS_ADDR_PEND 4'h8
`define MPS_ADDR_ACTIVE 4'hc
`define MPS_CTRL_THREAD_UNPRIVILEGED_BIT 0
`define MPS_CTRL_SPSEL 1
`define MPS_CTRL_RST 2'h0
`define MPS_NUM_EXC 8
`define MPS_EXC_SVC 3'h0
`define MPS_EXC_FAULT 3'h1
`define MPS_IRQ_BASE 3'h2
`define MPS_VEC_BASE_RST 32'h0000_0000
`define MPS_RESET_VECTOR 32'h0000_0004
`endif

// [hdl/mps_pkg.sv]
// Types shared by the mode, privilege and exception state block.
// Assumes mps_regs.svh on the include path.
`default_nettype none
`include "mps_regs.svh"
package mps_pkg;
  typedef enum logic [0:0]
  {
    MPS_THREAD = 1'b0,
    MPS_HANDLER = 1'b1
  } mps_mode_t;
  typedef enum logic [1:0]
  {
    MPS_INACTIVE = 2'b00,
    MPS_PENDING = 2'b01,
    MPS_ACTIVE = 2'b10,
    MPS_ACT_PEND = 2'b11
  } mps_exc_state_t;
  typedef struct packed
  {
    logic privileged;
    logic use_psp;
    mps_mode_t mode;
  } mps_core_view_t;
  typedef struct packed
  {
    logic taken;
    logic [2:0] num;
    logic [31:0] vector;
  } mps_entry_t;
endpackage
`default_nettype wire

// [hdl/mps_core_state.sv]
// Mode, privilege, stack select and per-exception state tracking.
// Assumes a core pipeline that requests entry and return, and a Wishbone master.
//
// Operation
// RULE1: Reset and return to thread both leave the core in Thread mode.
// RULE2: Taking any exception puts the core in Handler mode.
// RULE3: Exception return is ignored unless the core is in Handler mode.
// RULE4: Without the privilege option every execution is privileged.
// RULE5: With the option, unprivileged execution is flagged for access restriction.
// RULE6: Handler mode execution is always privileged.
// RULE7: Thread privilege is Handler mode or the unprivileged bit at zero.
// RULE8: The unprivileged bit only takes effect when the option is built.
// RULE9: Two banked stack pointers are held; exactly one is active.
// RULE10: Handler mode always uses the main stack pointer.
// RULE11: Thread mode may use main or process stack pointer in either privilege.
// RULE12: Reset aborts work; release restarts from the fixed reset vector.
// RULE13: A supervisor call instruction raises its exception in program order.
// RULE14: A synchronous fault is raised with the instruction that caused it.
// RULE15: Faults are fatal; no fault status is recorded.
// RULE16: Interrupt lines are accepted at any time, apart from the instruction stream.
// RULE17: Each exception has a priority, a number and a vector for its handler.
// RULE18: An exception neither pending nor active is inactive.
// RULE19: An exception stays pending from its event until its entry starts.
// RULE20: An exception stays active from handler start until its return.
// RULE21: Entry may happen in the same cycle as the event, skipping pending. Here only SVC and fault skip it; an interrupt entered so still pends.
// RULE22: Only interrupts may be active and pending together.
// RULE23: Reset clears the unprivileged bit: privileged Thread on the main stack.
`default_nettype none
`include "mps_regs.svh"
module mps_core_state #(
  parameter bit HAS_UNPRIV = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Exception sources
  input wire logic svc_exec_i,
  input wire logic fault_i,
  input wire logic [`MPS_NUM_EXC-3:0] irq_i,
  // Core sequencing
  input wire logic entry_req_i,
  input wire logic [2:0] entry_num_i,
  input wire logic return_req_i,
  input wire logic return_to_thread_i,
  input wire logic [31:0] sp_main_wdata_i,
  input wire logic sp_main_we_i,
  input wire logic [31:0] sp_proc_wdata_i,
  input wire logic sp_proc_we_i,
  // Core view
  output mps_pkg::mps_core_view_t view_o,
  output mps_pkg::mps_entry_t entry_o,
  output logic [31:0] active_sp_o,
  output logic [31:0] restart_pc_o,
  output logic return_refused_o,
  output logic [`MPS_NUM_EXC*2-1:0] exc_state_o
);
  import mps_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] onehot8(input logic [2:0] n);
    onehot8 = 8'h01 << n;
  endfunction

  function automatic logic [31:0] vec_addr(input logic [2:0] n);
    vec_addr = `MPS_RESET_VECTOR + {27'h0, n, 2'h0} + 32'h0000_0008;
  endfunction

  // ****************************************
  // State
  // ****************************************
  mps_mode_t mode_r, mode_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] sp_main_r, sp_proc_r;
  logic [7:0] pend_r, pend_nxt;
  logic [7:0] act_r, act_nxt;
  logic [7:0] prio_r [0:7];
  logic ack_r;
  logic [31:0] dat_r;
  mps_entry_t entry_r;
  logic refused_r;
  logic [31:0] restart_r;

  // ****************************************
  // Decode
  // ****************************************
  wire logic wb_req = cyc_i && stb_i && !ack_r;
  wire logic wr_ctrl = wb_req && we_i && adr_i == `MPS_ADDR_CTRL && sel_i[0];
  wire logic wr_prio = wb_req && we_i && adr_i == `MPS_ADDR_STATUS;
  wire logic in_handler = mode_r == MPS_HANDLER;
  wire logic ret_ok = return_req_i && in_handler; // RULE3
  wire logic ret_bad = return_req_i && !in_handler; // RULE3
  wire logic [7:0] events = {irq_i, fault_i, svc_exec_i}; // RULE13 RULE14 RULE16
  wire logic [7:0] ent_oh = entry_req_i ? onehot8(entry_num_i) : 8'h00;
  wire logic [7:0] ret_oh = ret_ok ? onehot8(entry_num_i) : 8'h00;
  wire logic [7:0] sync_mask = 8'h03; // RULE15
  wire logic thread_unprivileged_bit_eff = HAS_UNPRIV && ctrl_r[`MPS_CTRL_THREAD_UNPRIVILEGED_BIT]; // RULE4 RULE8
  wire logic priv = in_handler || !thread_unprivileged_bit_eff; // RULE6 RULE7 RULE5
  wire logic psp_sel = !in_handler && ctrl_r[`MPS_CTRL_SPSEL]; // RULE10 RULE11

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    mode_nxt = mode_r;
    if (entry_req_i)
      mode_nxt = MPS_HANDLER; // RULE2
    else if (ret_ok && return_to_thread_i)
      mode_nxt = MPS_THREAD; // RULE1
    ctrl_nxt = ctrl_r;
    if (wr_ctrl && priv)
      ctrl_nxt = dat_i[1:0];
    // Event wins over entry clear: a fresh event re-pends
    pend_nxt = (pend_r & ~ent_oh) | events; // RULE19 RULE21
    // Synchronous exceptions never pend while active
    pend_nxt = pend_nxt & ~(sync_mask & (act_r | ent_oh)); // RULE22
    act_nxt = (act_r & ~ret_oh) | ent_oh; // RULE20
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= MPS_THREAD; // RULE1 RULE12
      ctrl_r <= `MPS_CTRL_RST; // RULE23
      pend_r <= 8'h00; // RULE18
      act_r <= 8'h00;
      restart_r <= `MPS_RESET_VECTOR; // RULE12
    end
    else
    begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      pend_r <= pend_nxt;
      act_r <= act_nxt;
    end
  end

  // Banked stack pointers, no fault status kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sp_main_r <= 32'h0000_0000; // RULE9
      sp_proc_r <= 32'h0000_0000;
    end
    else
    begin
      if (sp_main_we_i)
        sp_main_r <= sp_main_wdata_i;
      if (sp_proc_we_i)
        sp_proc_r <= sp_proc_wdata_i;
    end
  end

  // Entry record: taken flag, number and vector
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      entry_r <= '0;
      refused_r <= 1'b0;
    end
    else
    begin
      entry_r.taken <= entry_req_i;
      entry_r.num <= entry_num_i; // RULE17
      entry_r.vector <= vec_addr(entry_num_i); // RULE17
      refused_r <= ret_bad; // RULE3
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
        prio_r[i] <= 8'h00;
    end
    else if (wr_prio && priv && sel_i[0])
      prio_r[dat_i[10:8]] <= dat_i[7:0]; // RULE17
  end

  // ****************************************
  // Bus read
  // ****************************************
  wire logic [31:0] rd_mux =
    adr_i == `MPS_ADDR_CTRL ? {30'h0, ctrl_r} :
    adr_i == `MPS_ADDR_STATUS ? {16'h0, prio_r[dat_i[10:8]], 5'h0, priv, psp_sel, mode_r} :
    adr_i == `MPS_ADDR_PEND ? {24'h0, pend_r} :
    adr_i == `MPS_ADDR_ACTIVE ? {24'h0, act_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= wb_req;
      dat_r <= rd_mux;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      exc_state_o[2*i +: 2] = {act_r[i], pend_r[i]}; // RULE18 RULE22
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign view_o = '{privileged: priv, use_psp: psp_sel, mode: mode_r};
  assign active_sp_o = psp_sel ? sp_proc_r : sp_main_r; // RULE9 RULE10
  assign entry_o = entry_r;
  assign restart_pc_o = restart_r;
  assign return_refused_o = refused_r;
endmodule
`default_nettype wire

// [sim/mps_cs_assertions.sv]
// Checker on the core state block ports.
// Assumes a bind onto mps_core_state, one clock domain.
`default_nettype none
module mps_cs_assertions
(
  // Clock, reset and inputs
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic svc_exec_i,
  input wire logic [5:0] irq_i,
  input wire logic entry_req_i,
  input wire logic [2:0] entry_num_i,
  input wire logic return_req_i,
  input wire logic return_to_thread_i,
  // Outputs
  input wire mps_pkg::mps_core_view_t view_o,
  input wire mps_pkg::mps_entry_t entry_o,
  input wire logic [31:0] restart_pc_o,
  input wire logic return_refused_o,
  input wire logic [15:0] exc_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mps_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic hnd = view_o.mode == MPS_HANDLER;
  wire logic quiet = !entry_req_i && !return_req_i;
  sequence ent_s; entry_req_i && !return_req_i; endsequence
  sequence in_s; hnd && entry_o.taken; endsequence
  entry_mode_a: assert property (ent_s |=> in_s)
    else $error("entry mode");
  hnd_priv_a: assert property (hnd |-> view_o.privileged)
    else $error("handler unprivileged");
  ret_thread_a: assert property (return_req_i && !entry_req_i && !hnd |=> !hnd)
    else $error("return left thread");
  to_thread_a: assert property (return_req_i && return_to_thread_i && !entry_req_i && hnd |=> !hnd)
    else $error("return mode");
  refuse_a: assert property (return_req_i && !hnd |=> return_refused_o)
    else $error("no refusal");
  no_refuse_a: assert property (!return_req_i |=> !return_refused_o)
    else $error("stray refusal");
  vec_a: assert property (entry_req_i |=> entry_o.vector == 32'hc + {$past(entry_num_i), 2'h0})
    else $error("vector");
  svc_act_a: assert property (ent_s ##0 entry_num_i == 3'h0 |=> exc_state_o[1:0] == 2'b10)
    else $error("svc active");
  svc_pend_a: assert property (svc_exec_i && quiet |=> ^exc_state_o[1:0])
    else $error("svc state");
  irq_pend_a: assert property (irq_i[0] && !entry_req_i |=> exc_state_o[4])
    else $error("irq pend");
  pend_hold_a: assert property (exc_state_o[4] && !entry_req_i |=> exc_state_o[4])
    else $error("pend lost");
  restart_a: assert property (restart_pc_o == 32'h4)
    else $error("restart point");
endmodule
bind mps_core_state mps_cs_assertions u_chk (.clk_i, .rst_i, .svc_exec_i, .irq_i,
  .entry_req_i, .entry_num_i, .return_req_i, .return_to_thread_i, .view_o, .entry_o,
  .restart_pc_o, .return_refused_o, .exc_state_o);
`default_nettype wire

// [sim/mps_src_model.sv]
// Model of the exception sources outside the core.
// Assumes the bench pulses req_i for one cycle per event.
`default_nettype none
module mps_src_model
(
  // Clock and requests
  input wire logic clk_i,
  input wire logic [7:0] req_i,
  // Raised events
  output logic svc_o,
  output logic fault_o,
  output logic [5:0] irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Events launched one edge after the request
  always_ff @(posedge clk_i)
  begin
    svc_o <= req_i[0];
    fault_o <= req_i[1];
    irq_o <= req_i[7:2];
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Bench for the core state block: bus, events, entry and return.
// Assumes design, source model and checker compiled first.
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t mismatch line %0d", $time, `__LINE__); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mps_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cs = 1'b0, we = 1'b0, ent = 1'b0, ret = 1'b0;
  logic ret_th = 1'b0, spm_we = 1'b0, spp_we = 1'b0, ack, refd, supervisor_call_instruction, flt;
  logic [3:0] adr = 4'h0;
  logic [2:0] num = 3'h0;
  logic [7:0] req = 8'h0;
  logic [5:0] irq;
  logic [15:0] st;
  logic [31:0] dat = 32'h0, spm = 32'h1000, spp = 32'h2000, rd, q, asp, rpc;
  mps_core_view_t view;
  mps_entry_t eo;
  int num_errors = 0, tests_run = 0;
  mps_src_model u_src (.clk_i, .req_i(req), .svc_o(supervisor_call_instruction), .fault_o(flt), .irq_o(irq));
  mps_core_state u_dut (.clk_i, .rst_i, .cyc_i(cs), .stb_i(cs), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(dat), .dat_o(rd), .ack_o(ack), .svc_exec_i(supervisor_call_instruction), .fault_i(flt),
    .irq_i(irq), .entry_req_i(ent), .entry_num_i(num), .return_req_i(ret),
    .return_to_thread_i(ret_th), .sp_main_wdata_i(spm), .sp_main_we_i(spm_we),
    .sp_proc_wdata_i(spp), .sp_proc_we_i(spp_we), .view_o(view), .entry_o(eo),
    .active_sp_o(asp), .restart_pc_o(rpc), .return_refused_o(refd), .exc_state_o(st));
  initial forever #25 clk_i = ~clk_i;
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 9);
    if (n >= 9)
    begin
      num_errors++;
      results();
    end
    q = rd;
    cs <= 1'b0;
    #1;
  endtask
  task automatic cyc1(input logic e, r, t, input logic [2:0] n);
    @(posedge clk_i);
    ent <= e;
    ret <= r;
    ret_th <= t;
    num <= n;
    req <= 8'h0;
    @(posedge clk_i);
    ent <= 1'b0;
    ret <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    `CHK(view, 3'b100)
    `CHK(rpc, 32'h4)
    `CHK(st, 16'h0)
    wb(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0)
  endtask
  task automatic t_stack();
    @(posedge clk_i);
    spm_we <= 1'b1;
    spp_we <= 1'b1;
    @(posedge clk_i);
    spm_we <= 1'b0;
    spp_we <= 1'b0;
    #1;
    `CHK(asp, 32'h1000)
    wb(1'b1, 4'h0, 32'h2);
    `CHK(view, 3'b110)
    `CHK(asp, 32'h2000)
    @(posedge clk_i);
    req <= 8'h1;
    cyc1(1'b0, 1'b0, 1'b0, 3'h0);
    `CHK(st[1:0], 2'b01)
    cyc1(1'b1, 1'b0, 1'b0, 3'h0);
    `CHK(view.mode, MPS_HANDLER)
    `CHK(asp, 32'h1000)
    `CHK(eo, {1'b1, 3'h0, 32'hc})
    `CHK(st[1:0], 2'b10)
    cyc1(1'b0, 1'b1, 1'b1, 3'h0);
    `CHK(view, 3'b110)
    `CHK(st[1:0], 2'b00)
  endtask
  task automatic t_priv();
    wb(1'b1, 4'h0, 32'h3);
    `CHK(view, 3'b010)
    wb(1'b1, 4'h0, 32'h0);
    `CHK(view, 3'b010)
    wb(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    @(posedge clk_i);
    req <= 8'h2;
    cyc1(1'b0, 1'b0, 1'b0, 3'h0);
    `CHK(st[3:2], 2'b01)
    cyc1(1'b1, 1'b0, 1'b0, 3'h1);
    `CHK(view.privileged, 1'b1)
    cyc1(1'b0, 1'b1, 1'b1, 3'h1);
    `CHK(view, 3'b010)
    `CHK(st[3:2], 2'b00)
  endtask
  task automatic t_irq();
    cyc1(1'b0, 1'b1, 1'b1, 3'h0);
    `CHK(refd, 1'b1)
    `CHK(view.mode, MPS_THREAD)
    @(posedge clk_i);
    req <= 8'h4;
    cyc1(1'b1, 1'b0, 1'b0, 3'h2);
    `CHK(st[5:4], 2'b11)
    `CHK(eo.vector, 32'h14)
    cyc1(1'b0, 1'b1, 1'b1, 3'h2);
    `CHK(st[5:4], 2'b01)
    cyc1(1'b1, 1'b0, 1'b0, 3'h2);
    `CHK(st[5:4], 2'b10)
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_stack();
    t_priv();
    t_irq();
    results();
  end
endmodule
`default_nettype wire
